// ===== hdl/rtrb_cause_latch.v
`timescale 1ns/1ps
`default_nettype none
`include "rtrb_defs.vh"

// Sticky interrupt cause vector with clear-on-read
module rtrb_cause_latch (
    input  wire        clk,
    input  wire        reset,
    input  wire [8:0]  cause_pulse,
    input  wire [7:0]  cause_enable,
    input  wire        read_clear,
    output reg  [8:0]  cause_vector
);
    wire [8:0] gated;

    // Interface error has no enable bit
    assign gated = cause_pulse & {1'b1, cause_enable}; // see [RULE_17]

    // New events win over the clear of a simultaneous read
    always @(posedge clk) begin
        if (reset) begin
            cause_vector <= 9'h000;
        end else if (read_clear) begin
            cause_vector <= gated; // see [RULE_04]
        end else begin
            cause_vector <= cause_vector | gated; // see [RULE_15]
        end
    end
endmodule

`default_nettype wire

// ===== hdl/rtrb_defs.vh
// Functional notes
// [RULE_01] Host wins the shared bus, then strobes register select and read/write control.
// [RULE_02] Seven word registers decoded at consecutive addresses 0x0000 to 0x0006.
// [RULE_03] Configuration, time tag and frame tag registers are host readable and writable.
// [RULE_04] Reading the interrupt vector returns latched causes, then clears them all.
// [RULE_05] Mode bit 4 selects descriptor stack B when set, A when clear; reset 0.
// [RULE_06] Mode bit 3 enables memory error correction; reset 0.
// [RULE_07] Mode bit 2 selects internal wrap-around data for subaddress 30; reset 1.
// [RULE_08] Mode bit 1 enables command illegalization checking; reset 0.
// [RULE_09] Mode bit 0 accepts broadcast commands; reset 1, mode reset value 0x0005.
// [RULE_10] Time base register holds a 16-bit frame duration, reset zero.
// [RULE_11] Mask bits 15..11 hold the watched subaddress; reset 0.
// [RULE_12] Mask bits 10..8 encode descriptor stack size; 000 is one descriptor; reset 000.
// [RULE_13] Mask bits 7..0 enable causes; only end of message enabled after reset.
// [RULE_14] Interface bits 3..0 set access wait states; upper bits unused; reset 0000.
// [RULE_15] Vector bits 8..0 latch the nine causes in order; reset 0.
// [RULE_16] Time tag holds time counter, frame tag holds frame number; both reset 0.
// [RULE_17] Host interface error cause has no mask bit and is always latched.
// [RULE_18] Access lasts 400 ns until first interface register write, then programmed waits.
// [RULE_19] Unused bits read zero; writes to unused bits and the vector are ignored.
`ifndef RTRB_DEFS_VH
`define RTRB_DEFS_VH

`define RTRB_ADDR_MODE      3'h0
`define RTRB_ADDR_FRAME_DUR 3'h1
`define RTRB_ADDR_MASK      3'h2
`define RTRB_ADDR_IFACE     3'h3
`define RTRB_ADDR_VECTOR    3'h4
`define RTRB_ADDR_TIME_TAG  3'h5
`define RTRB_ADDR_FRAME_TAG 3'h6

`define RTRB_MODE_RESET     16'h0005
`define RTRB_MODE_MASK      16'h001f
`define RTRB_MASK_RESET     16'h0001
`define RTRB_IFACE_MASK     16'h000f
`define RTRB_VECTOR_MASK    16'h01ff

`define RTRB_BIT_STACK_SEL  4
`define RTRB_BIT_ECC_EN     3
`define RTRB_BIT_WRAP_SEL   2
`define RTRB_BIT_ILL_EN     1
`define RTRB_BIT_BCAST_EN   0

// Default access length before the interface register is first written
`define RTRB_DEFAULT_ACCESS_NS 400
`define RTRB_CLK_PERIOD_NS     10
// 400 ns at 10 ns per cycle is 40 cycles, so 39 waits beyond the first cycle
`define RTRB_DEFAULT_WAITS     6'h27

`endif

// ===== hdl/rtrb_register_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "rtrb_defs.vh"

// Internal register bank of the remote terminal core
module rtrb_register_bank (
    input  wire        CORE_CLK,
    input  wire        RESET,
    input  wire        BUS_GRANTED,
    input  wire        REGISTER_SELECT_N,
    input  wire        REGISTER_READ_WRITE,
    input  wire [2:0]  REG_ADDR,
    input  wire [15:0] REG_WDATA,
    output reg  [15:0] REG_RDATA,
    input  wire [8:0]  CAUSE_EVENT,
    input  wire        TIME_TAG_LOAD,
    input  wire [15:0] TIME_TAG_VALUE,
    input  wire        FRAME_TAG_LOAD,
    input  wire [15:0] FRAME_TAG_VALUE,
    output reg         ACTIVE_STACK_SELECT,
    output reg         ECC_ENABLE,
    output reg         INTERNAL_WRAP_SELECT,
    output reg         ILLEGAL_CHECK_ENABLE,
    output reg         BROADCAST_ENABLE,
    output reg  [15:0] FRAME_LENGTH,
    output reg  [4:0]  WATCHED_SUBADDRESS,
    output reg  [2:0]  DESCRIPTOR_STACK_SIZE,
    output reg  [7:0]  CAUSE_ENABLE,
    output reg  [5:0]  ACCESS_WAIT_COUNT,
    output reg  [8:0]  INTERRUPT_CAUSE_VECTOR,
    output reg  [15:0] TIME_IN_FRAME,
    output reg  [15:0] FRAME_NUMBER
);
    reg  [15:0] terminal_mode_config;
    reg  [15:0] frame_duration_config;
    reg  [15:0] interrupt_mask_config;
    reg  [15:0] host_interface_config;
    reg         iface_written;
    reg  [15:0] time_in_frame_counter;
    reg  [15:0] frame_number_register;
    wire [8:0]  cause_vector;
    wire        access;
    wire        wr;
    wire        rd;
    reg  [15:0] next_rdata;

    // Access only while the host holds the shared bus
    assign access = BUS_GRANTED & ~REGISTER_SELECT_N; // see [RULE_01]
    assign wr     = access & ~REGISTER_READ_WRITE;
    assign rd     = access & REGISTER_READ_WRITE;

    function is_write;
        input [2:0] a;
        input [2:0] target;
        begin
            is_write = wr && (a == target);
        end
    endfunction

    // Configuration registers, masked to their used bits
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            terminal_mode_config  <= `RTRB_MODE_RESET; // see [RULE_09]
            frame_duration_config <= 16'h0000; // see [RULE_10]
            interrupt_mask_config <= `RTRB_MASK_RESET; // see [RULE_13]
            host_interface_config <= 16'h0000; // see [RULE_14]
            iface_written         <= 1'b0;
        end else begin
            if (is_write(REG_ADDR, `RTRB_ADDR_MODE))
                terminal_mode_config <= REG_WDATA & `RTRB_MODE_MASK; // see [RULE_19]
            if (is_write(REG_ADDR, `RTRB_ADDR_FRAME_DUR))
                frame_duration_config <= REG_WDATA; // see [RULE_03]
            if (is_write(REG_ADDR, `RTRB_ADDR_MASK))
                interrupt_mask_config <= REG_WDATA;
            if (is_write(REG_ADDR, `RTRB_ADDR_IFACE)) begin
                host_interface_config <= REG_WDATA & `RTRB_IFACE_MASK;
                iface_written         <= 1'b1; // see [RULE_18]
            end
        end
    end

    // Time and frame tags; host write wins over a core load
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            time_in_frame_counter <= 16'h0000; // see [RULE_16]
            frame_number_register <= 16'h0000;
        end else begin
            if (is_write(REG_ADDR, `RTRB_ADDR_TIME_TAG))
                time_in_frame_counter <= REG_WDATA; // see [RULE_03]
            else if (TIME_TAG_LOAD)
                time_in_frame_counter <= TIME_TAG_VALUE;
            if (is_write(REG_ADDR, `RTRB_ADDR_FRAME_TAG))
                frame_number_register <= REG_WDATA;
            else if (FRAME_TAG_LOAD)
                frame_number_register <= FRAME_TAG_VALUE;
        end
    end

    // Cause vector, cleared by a host read
    rtrb_cause_latch u_cause (
        .clk          (CORE_CLK),
        .reset        (RESET),
        .cause_pulse  (CAUSE_EVENT),
        .cause_enable (interrupt_mask_config[7:0]),
        .read_clear   (rd && (REG_ADDR == `RTRB_ADDR_VECTOR)), // see [RULE_04]
        .cause_vector (cause_vector)
    );

    // Read data mux
    always @* begin
        case (REG_ADDR) // see [RULE_02]
            `RTRB_ADDR_MODE:      next_rdata = terminal_mode_config;
            `RTRB_ADDR_FRAME_DUR: next_rdata = frame_duration_config;
            `RTRB_ADDR_MASK:      next_rdata = interrupt_mask_config;
            `RTRB_ADDR_IFACE:     next_rdata = host_interface_config;
            `RTRB_ADDR_VECTOR:    next_rdata = {7'h00, cause_vector}; // see [RULE_19]
            `RTRB_ADDR_TIME_TAG:  next_rdata = time_in_frame_counter;
            `RTRB_ADDR_FRAME_TAG: next_rdata = frame_number_register;
            default:              next_rdata = 16'h0000;
        endcase
    end

    // Registered outputs
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
        end else if (rd) begin
            REG_RDATA <= next_rdata;
        end
    end

    // Decoded fields toward the core
    always @(posedge CORE_CLK) begin
        ACTIVE_STACK_SELECT    <= terminal_mode_config[`RTRB_BIT_STACK_SEL]; // see [RULE_05]
        ECC_ENABLE             <= terminal_mode_config[`RTRB_BIT_ECC_EN]; // see [RULE_06]
        INTERNAL_WRAP_SELECT   <= terminal_mode_config[`RTRB_BIT_WRAP_SEL]; // see [RULE_07]
        ILLEGAL_CHECK_ENABLE   <= terminal_mode_config[`RTRB_BIT_ILL_EN]; // see [RULE_08]
        BROADCAST_ENABLE       <= terminal_mode_config[`RTRB_BIT_BCAST_EN]; // see [RULE_09]
        FRAME_LENGTH           <= frame_duration_config;
        WATCHED_SUBADDRESS     <= interrupt_mask_config[15:11]; // see [RULE_11]
        DESCRIPTOR_STACK_SIZE  <= interrupt_mask_config[10:8]; // see [RULE_12]
        CAUSE_ENABLE           <= interrupt_mask_config[7:0];
        INTERRUPT_CAUSE_VECTOR <= cause_vector;
        TIME_IN_FRAME          <= time_in_frame_counter;
        FRAME_NUMBER           <= frame_number_register;
        if (iface_written)
            ACCESS_WAIT_COUNT <= {2'b00, host_interface_config[3:0]}; // see [RULE_18]
        else
            ACCESS_WAIT_COUNT <= `RTRB_DEFAULT_WAITS;
    end
endmodule

`default_nettype wire

// ===== testbench/rtrb_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the register bank
module rtrb_checker (
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic        BUS_GRANTED,
    input wire logic        REGISTER_SELECT_N,
    input wire logic        REGISTER_READ_WRITE,
    input wire logic [2:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic [8:0]  CAUSE_EVENT,
    input wire logic        ACTIVE_STACK_SELECT,
    input wire logic        BROADCAST_ENABLE,
    input wire logic [15:0] FRAME_LENGTH,
    input wire logic [7:0]  CAUSE_ENABLE,
    input wire logic [5:0]  ACCESS_WAIT_COUNT,
    input wire logic [8:0]  INTERRUPT_CAUSE_VECTOR
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Accesses taken at an edge
    wire logic rd = BUS_GRANTED && !REGISTER_SELECT_N && REGISTER_READ_WRITE;
    wire logic wr = BUS_GRANTED && !REGISTER_SELECT_N && !REGISTER_READ_WRITE;
    a_vector_read_clear: assert property (rd && REG_ADDR == 3'h4 && CAUSE_EVENT == 9'h000
        |-> ##2 INTERRUPT_CAUSE_VECTOR == 9'h000) else $error("vector kept after read");
    a_mode_write_bits: assert property (wr && REG_ADDR == 3'h0
        |-> ##2 ACTIVE_STACK_SELECT == $past(REG_WDATA[4], 2) && BROADCAST_ENABLE == $past(REG_WDATA[0], 2))
        else $error("mode bits wrong");
    a_frame_len_write: assert property (wr && REG_ADDR == 3'h1
        |-> ##2 FRAME_LENGTH == $past(REG_WDATA, 2)) else $error("frame length wrong");
    a_mask_enable_write: assert property (wr && REG_ADDR == 3'h2
        |-> ##2 CAUSE_ENABLE == $past(REG_WDATA[7:0], 2)) else $error("cause enable wrong");
    a_wait_count_write: assert property (wr && REG_ADDR == 3'h3
        |-> ##2 ACCESS_WAIT_COUNT == {2'b00, $past(REG_WDATA[3:0], 2)}) else $error("wait count wrong");
    a_unmapped_read_zero: assert property (rd && REG_ADDR == 3'h7 |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!rd |=> $stable(REG_RDATA))
        else $error("read data moved without read");
    a_reset_out_values: assert property ($fell(RESET) |-> !ACTIVE_STACK_SELECT && BROADCAST_ENABLE
        && CAUSE_ENABLE == 8'h01 && FRAME_LENGTH == 16'h0000 && ACCESS_WAIT_COUNT == 6'h27)
        else $error("reset outputs wrong");
endmodule
`default_nettype wire

// ===== testbench/rtrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host processor on the shared bus
module rtrb_host_model (
    input  wire logic        clk,
    output var  logic        grant,
    output var  logic        sel_n,
    output var  logic        rw,
    output var  logic [2:0]  addr,
    output var  logic [15:0] wdata
);
    initial {grant, sel_n, rw, addr, wdata} = {3'b010, 3'h0, 16'h0000};
    // One access held over its taking edge; released lines show the inverse
    task automatic acc(input logic r, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        {grant, sel_n, rw, addr, wdata} = {1'b1, 1'b0, r, a, d};
        @(posedge clk);
        #1;
        {grant, sel_n, addr, wdata} = {1'b0, 1'b1, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ===== testbench/rtrb_register_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module rtrb_register_bank_test;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        tl = 1'b0;
    logic        fl = 1'b0;
    logic [8:0]  cause = 9'h000;
    logic [15:0] tv = 16'h0000;
    logic [15:0] fv = 16'h0000;
    wire logic        grant, sel_n, rw, st, be, ecc, wrap, ill;
    wire logic [5:0]  wc;
    wire logic [2:0]  addr;
    wire logic [15:0] wdata, rdata;
    integer      mismatches = 0;
    integer      n_compared = 0;
    integer      i;
    logic [15:0] rst_v [0:7] = '{16'h0005, 16'h0, 16'h0001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] all_v [0:7] = '{16'h001f, 16'hffff, 16'hffff, 16'h000f, 16'h0, 16'hffff, 16'hffff, 16'h0};
    // Free-running core clock
    always #5 core_clk = ~core_clk;
    rtrb_host_model u_rtrb_host_model (.clk(core_clk), .grant(grant), .sel_n(sel_n), .rw(rw), .addr(addr),
        .wdata(wdata));
    rtrb_register_bank u_rtrb_register_bank (.CORE_CLK(core_clk), .RESET(reset), .BUS_GRANTED(grant),
        .REGISTER_SELECT_N(sel_n), .REGISTER_READ_WRITE(rw), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .CAUSE_EVENT(cause), .TIME_TAG_LOAD(tl), .TIME_TAG_VALUE(tv), .FRAME_TAG_LOAD(fl),
        .FRAME_TAG_VALUE(fv), .ACTIVE_STACK_SELECT(st), .ECC_ENABLE(ecc), .INTERNAL_WRAP_SELECT(wrap),
        .ILLEGAL_CHECK_ENABLE(ill), .BROADCAST_ENABLE(be), .FRAME_LENGTH(), .WATCHED_SUBADDRESS(),
        .DESCRIPTOR_STACK_SIZE(), .CAUSE_ENABLE(), .ACCESS_WAIT_COUNT(wc), .INTERRUPT_CAUSE_VECTOR(),
        .TIME_IN_FRAME(), .FRAME_NUMBER());
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        u_rtrb_host_model.acc(1'b1, a, 16'h0000);
        chk("rdata", e, rdata);
    endtask
    task automatic pulse(input logic [8:0] c);
        #1 cause = c;
        @(posedge core_clk);
        #1 cause = 9'h000;
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #1 reset = 1'b0;
        for (i = 0; i < 8; i++) rd(i[2:0], rst_v[i]);
        chk("wait count", 16'h0027, {10'h000, wc});
        chk("wrap select", 16'h0001, {15'h0000, wrap});
        chk("ecc enable", 16'h0000, {15'h0000, ecc});
        chk("illegal check", 16'h0000, {15'h0000, ill});
        $display("reset values done");
        for (i = 0; i < 8; i++) u_rtrb_host_model.acc(1'b0, i[2:0], 16'hffff);
        for (i = 0; i < 8; i++) rd(i[2:0], all_v[i]);
        chk("stack select", 16'h1, {15'h0, st});
        chk("ecc enable", 16'h0001, {15'h0000, ecc});
        chk("illegal check", 16'h0001, {15'h0000, ill});
        chk("wait count", 16'h000f, {10'h000, wc});
        $display("write readback done");
        for (i = 0; i < 8; i++) u_rtrb_host_model.acc(1'b0, 3'h2, {5'h15, i[2:0], 8'hff});
        rd(3'h2, 16'hafff);
        pulse(9'h1ff);
        rd(3'h4, 16'h01ff);
        rd(3'h4, 16'h0000);
        u_rtrb_host_model.acc(1'b0, 3'h2, 16'h0000);
        pulse(9'h1ff);
        rd(3'h4, 16'h0100);
        $display("vector done");
        {tl, tv, fl, fv} = {1'b1, 16'h1234, 1'b1, 16'habcd};
        @(posedge core_clk);
        #1 {tl, fl} = 2'b00;
        rd(3'h5, 16'h1234);
        rd(3'h6, 16'habcd);
        $display("tag load done");
        end_sim();
    end
endmodule
bind rtrb_register_bank rtrb_checker u_rtrb_checker (.*);
`default_nettype wire
